// *** rtl/lsc_pkg.sv ***
// Package with offsets, field positions and reset values of the link control bank.
package lsc_pkg;
   localparam logic [7:0] LINK_CAPABILITIES_TWO_OFS = 8'h6C;
   localparam logic [7:0] LINK_CONTROL_TWO_OFS = 8'h70;
   localparam logic [7:0] LINK_SHADOW_OFS = 8'h80;
   localparam int TARGET_SPEED_LSB = 0;
   localparam int TARGET_SPEED_MSB = 3;
   localparam int COMPLIANCE_BIT = 4;
   localparam int AUTO_SPEED_BLOCK_BIT = 5;
   localparam int DEEMPH_SEL_BIT = 6;
   localparam int MARGIN_LSB = 7;
   localparam int MARGIN_MSB = 9;
   localparam logic [3:0] SPEED_GEN1 = 4'h1;
   localparam logic [3:0] SPEED_GEN2 = 4'h2;
   localparam logic [3:0] TARGET_SPEED_RST = 4'h2;
   localparam logic COMPLIANCE_RST = 1'b0;
   localparam logic DEEMPH_SEL_RST = 1'b0;
   localparam logic [2:0] MARGIN_RST = 3'h0;
   localparam logic [2:0] MARGIN_NORMAL = 3'h0;
   localparam logic [2:0] MARGIN_LAST_VALID = 3'h5;
   localparam logic DEEMPH_6DB = 1'b0;
   localparam logic DEEMPH_3P5DB = 1'b1;
   localparam logic [31:0] CAP2_VALUE = 32'h0000_0000;
endpackage

// *** rtl/lsc_wb_if.sv ***
// Interface carrying the decoded register access from the bus slave to the bank.
`timescale 1ns/10ps
interface lsc_wb_if;
   logic wr_en;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [3:0] sel;
   logic ack;
   modport slave (output wr_en, output addr, output wdata, output sel,
      input ack);
   modport bank (input wr_en, input addr, input wdata, input sel,
      output ack);
endinterface

// *** rtl/lsc_wb_slave.sv ***
// Classic Wishbone slave front end producing one-cycle write strobes and ack.
`timescale 1ns/10ps
module lsc_wb_slave
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic o_wb_ack,
   lsc_wb_if.slave bus
);
   logic ack_q;

   // Ack one cycle after the request and drop it the cycle after.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         ack_q <= 1'b0;
      else
         ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
   end

   // The write strobe coincides with ack, so it lands at the master's edge.
   assign bus.wr_en = ack_q && i_wb_we;
   assign bus.addr = i_wb_adr;
   assign bus.wdata = i_wb_dat;
   assign bus.sel = i_wb_sel;
   assign o_wb_ack = ack_q;
endmodule

// *** rtl/lsc_link_ctl.sv ***
// Link speed, compliance, de-emphasis and transmit margin register bank.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
module lsc_link_ctl
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_is_downstream,
   input wire logic i_hot_reset,
   input wire logic i_ltssm_polling_cfg_entry,
   input wire logic i_ltssm_recovery_speed,
   input wire logic i_ltssm_recovery_rcvrlock,
   input wire logic i_link_at_gen2,
   input wire logic i_low_swing,
   input wire logic [2:0] i_serdes_tx_global_ctrl,
   input wire logic [2:0] i_serdes_tx_lane_ctrl,
   output logic [3:0] o_adv_speed_max,
   output logic [3:0] o_compliance_speed,
   output logic o_compliance_force,
   output logic o_deemph_apply,
   output logic o_deemph_advertise,
   output logic o_deemph_tx,
   output logic [2:0] o_tx_margin,
   output logic [2:0] o_tx_drive_level,
   output logic o_autonomous_speed_en
);
   lsc_wb_if bus ();

   logic [3:0] target_speed_limit_q;
   logic compliance_entry_q;
   logic deemphasis_select_q;
   logic [2:0] tx_margin_q;
   logic deemph_active_q;
   logic [2:0] margin_active_q;
   logic comp_force_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic [15:0] ctl2_view;
   logic wr_ctl2;
   logic wr_lo;
   logic wr_hi;

   lsc_wb_slave u_slave
   (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we),
      .i_wb_adr(i_wb_adr),
      .i_wb_dat(i_wb_dat),
      .i_wb_sel(i_wb_sel),
      .o_wb_ack(o_wb_ack),
      .bus(bus)
   );

   // Byte lanes for the 16-bit link control two word at its aligned address.
   assign wr_ctl2 = bus.wr_en && (bus.addr == lsc_pkg::LINK_CONTROL_TWO_OFS);
   assign wr_lo = wr_ctl2 && bus.sel[0];
   assign wr_hi = wr_ctl2 && bus.sel[1];

   // Sticky fields are cleared only by i_arst_n, the fundamental reset.
   // Hot reset is deliberately not an input to these flops.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         target_speed_limit_q <= lsc_pkg::TARGET_SPEED_RST;
      else if (wr_lo)
         target_speed_limit_q <= bus.wdata[lsc_pkg::TARGET_SPEED_MSB:
            lsc_pkg::TARGET_SPEED_LSB];
   end

   // Compliance entry bit, sticky, resets to zero.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         compliance_entry_q <= lsc_pkg::COMPLIANCE_RST;
      else if (wr_lo)
         compliance_entry_q <= bus.wdata[lsc_pkg::COMPLIANCE_BIT];
   end

   // De-emphasis select is not sticky, so a hot reset restores it.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         deemphasis_select_q <= lsc_pkg::DEEMPH_SEL_RST;
      else if (i_hot_reset)
         deemphasis_select_q <= lsc_pkg::DEEMPH_SEL_RST;
      else if (wr_lo)
         deemphasis_select_q <= bus.wdata[lsc_pkg::DEEMPH_SEL_BIT];
   end

   // Transmit margin straddles both byte lanes; the LTSSM clear wins over
   // a software write in the same cycle so the link always trains normal.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         tx_margin_q <= lsc_pkg::MARGIN_RST;
      else if (i_ltssm_polling_cfg_entry)
         tx_margin_q <= lsc_pkg::MARGIN_NORMAL;
      else if (wr_lo || wr_hi)
         tx_margin_q <= {wr_hi ?
            bus.wdata[lsc_pkg::MARGIN_MSB:lsc_pkg::MARGIN_LSB + 1] :
            tx_margin_q[2:1],
            wr_lo ? bus.wdata[lsc_pkg::MARGIN_LSB] : tx_margin_q[0]};
   end

   // Compliance is latched on hot reset with the bit set and released by
   // clearing the bit; the speed comes from the target field.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         comp_force_q <= 1'b0;
      else if (!compliance_entry_q)
         comp_force_q <= 1'b0;
      else if (i_hot_reset)
         comp_force_q <= 1'b1;
   end

   // Applied de-emphasis follows the register only at Recovery.Speed.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         deemph_active_q <= lsc_pkg::DEEMPH_SEL_RST;
      else if (i_ltssm_recovery_speed)
         deemph_active_q <= deemphasis_select_q;
   end

   // Applied margin follows the register only at Recovery.RcvrLock.
   // Reserved codes are not applied; the previous value stays on the line.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         margin_active_q <= lsc_pkg::MARGIN_RST;
      else if (i_ltssm_polling_cfg_entry)
         margin_active_q <= lsc_pkg::MARGIN_NORMAL;
      else if (i_ltssm_recovery_rcvrlock &&
         tx_margin_q <= lsc_pkg::MARGIN_LAST_VALID)
         margin_active_q <= tx_margin_q;
   end

   // Speed steering: downstream advertises at most the target. A reserved
   // code is passed through unchanged; its outcome is undefined anyway.
   assign o_adv_speed_max = i_is_downstream ? target_speed_limit_q
      : lsc_pkg::SPEED_GEN2;
   assign o_compliance_speed = target_speed_limit_q;
   assign o_compliance_force = comp_force_q;
   assign o_autonomous_speed_en = 1'b0;

   // De-emphasis drive: downstream applies it at Gen2 without low swing, upstream only advertises.
   assign o_deemph_advertise = deemphasis_select_q;
   assign o_deemph_apply = i_is_downstream && i_link_at_gen2 &&
      !i_low_swing;
   assign o_deemph_tx = o_deemph_apply ? deemph_active_q
      : lsc_pkg::DEEMPH_6DB;

   // Normal margin hands drive level to the global and lane controls,
   // the lane value taking precedence when nonzero.
   assign o_tx_margin = margin_active_q;
   assign o_tx_drive_level = (margin_active_q != lsc_pkg::MARGIN_NORMAL) ?
      margin_active_q :
      ((i_serdes_tx_lane_ctrl != 3'h0) ? i_serdes_tx_lane_ctrl
      : i_serdes_tx_global_ctrl);

   // Software is trusted to leave the margin at default outside tests.
   assign ctl2_view = {6'h00, tx_margin_q, deemphasis_select_q, 1'b0,
      compliance_entry_q, target_speed_limit_q};

   // Read mux; unmapped offsets and the capabilities word read zero.
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (i_wb_adr)
         lsc_pkg::LINK_CAPABILITIES_TWO_OFS:
            rdata_d = lsc_pkg::CAP2_VALUE;
         lsc_pkg::LINK_CONTROL_TWO_OFS:
            rdata_d = {16'h0000, ctl2_view};
         lsc_pkg::LINK_SHADOW_OFS:
            // Force at bit 6, applied de-emphasis at bit 5, margin 2:0.
            rdata_d = {25'h0, comp_force_q, deemph_active_q,
               2'h0, margin_active_q};
         default:
            rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data is registered with the ack cycle.
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         rdata_q <= 32'h0000_0000;
      else if (i_wb_cyc && i_wb_stb && !o_wb_ack)
         rdata_q <= rdata_d;
   end

   assign o_wb_dat = rdata_q;
endmodule

// *** testbench/lsc_link_ctl_assertions.sv ***
// Checker for the link control bank, bound to its top module ports.
`timescale 1ns/10ps
module lsc_link_ctl_chk
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic i_is_downstream,
   input wire logic i_hot_reset,
   input wire logic i_ltssm_polling_cfg_entry,
   input wire logic i_ltssm_recovery_speed,
   input wire logic i_ltssm_recovery_rcvrlock,
   input wire logic i_link_at_gen2,
   input wire logic i_low_swing,
   input wire logic [3:0] o_adv_speed_max,
   input wire logic [3:0] o_compliance_speed,
   input wire logic o_deemph_apply,
   input wire logic o_deemph_tx,
   input wire logic [2:0] o_tx_margin,
   input wire logic o_autonomous_speed_en
);
   // One domain, so clock and reset are given once for all properties.
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // Bus answers one cycle after a request is taken, for one cycle only.
   a_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
      |=> o_wb_ack) else $error("ack missing after request");
   a_ack_single_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_cap2_reads_zero: assert property (
      o_wb_ack && !i_wb_we && i_wb_adr == 8'h6C |-> o_wb_dat == 32'h0)
      else $error("capabilities two word not zero");
   a_no_auto_speed: assert property (!o_autonomous_speed_en)
      else $error("autonomous speed enabled");
   a_adv_speed_cap: assert property (o_adv_speed_max ==
      (i_is_downstream ? o_compliance_speed : 4'h2))
      else $error("advertised speed not capped");
   a_deemph_gen1_off: assert property (
      !i_link_at_gen2 || i_low_swing |-> !o_deemph_apply)
      else $error("de-emphasis applied at low rate or low swing");
   a_deemph_tx_gated: assert property (
      !o_deemph_apply |-> !o_deemph_tx)
      else $error("de-emphasis driven while not applied");
   a_deemph_hold: assert property (
      o_deemph_apply && $past(o_deemph_apply)
      && !$past(i_ltssm_recovery_speed) && !$past(i_hot_reset)
      |-> $stable(o_deemph_tx)) else $error("de-emphasis moved early");
   a_margin_clear: assert property (
      i_ltssm_polling_cfg_entry |=> o_tx_margin == 3'h0)
      else $error("margin not cleared on polling entry");
   a_margin_hold: assert property (!i_ltssm_recovery_rcvrlock
      && !i_ltssm_polling_cfg_entry |=> $stable(o_tx_margin))
      else $error("margin applied outside receiver lock");
endmodule

bind lsc_link_ctl lsc_link_ctl_chk lsc_link_ctl_chk_inst (
   .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
   .i_is_downstream(i_is_downstream), .i_hot_reset(i_hot_reset),
   .i_ltssm_polling_cfg_entry(i_ltssm_polling_cfg_entry),
   .i_ltssm_recovery_speed(i_ltssm_recovery_speed),
   .i_ltssm_recovery_rcvrlock(i_ltssm_recovery_rcvrlock),
   .i_link_at_gen2(i_link_at_gen2), .i_low_swing(i_low_swing),
   .o_adv_speed_max(o_adv_speed_max),
   .o_compliance_speed(o_compliance_speed),
   .o_deemph_apply(o_deemph_apply), .o_deemph_tx(o_deemph_tx),
   .o_tx_margin(o_tx_margin), .o_autonomous_speed_en(o_autonomous_speed_en));

// *** testbench/tb_lsc_link_ctl.sv ***
// Self-checking bench for the link control bank over Wishbone.
`timescale 1ns/10ps
module tb_lsc_link_ctl;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, ds = 1'b1;
   logic g2 = 1'b1, ls = 1'b0, ack, frc, app, adv_p, dtx, auton;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat;
   logic [3:0] ev = 4'h0, sel = 4'hF, adv, cspd;
   logic [2:0] glob = 3'h5, lane = 3'h0, mar, drv;
   int mismatches = 0, comparisons = 0;
   // Free-running 200 MHz clock.
   always #2.5 clk = ~clk;
   lsc_link_ctl lsc_link_ctl_inst (.i_clk_sys(clk), .i_arst_n(rst_n),
      .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(dat), .o_wb_ack(ack),
      .i_is_downstream(ds), .i_hot_reset(ev[0]),
      .i_ltssm_polling_cfg_entry(ev[1]), .i_ltssm_recovery_speed(ev[2]),
      .i_ltssm_recovery_rcvrlock(ev[3]), .i_link_at_gen2(g2),
      .i_low_swing(ls), .i_serdes_tx_global_ctrl(glob),
      .i_serdes_tx_lane_ctrl(lane), .o_adv_speed_max(adv),
      .o_compliance_speed(cspd), .o_compliance_force(frc),
      .o_deemph_apply(app), .o_deemph_advertise(adv_p), .o_deemph_tx(dtx),
      .o_tx_margin(mar), .o_tx_drive_level(drv),
      .o_autonomous_speed_en(auton));
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Classic cycle: hold the request until ack is seen at a rising edge.
   // No answer time is assumed; only the watchdog ends a hung transfer.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do
      begin
         @(posedge clk);
      end
      while (ack !== 1'b1);
      rdat = dat;
      cyc <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(rdat, e);
   endtask
   // One-cycle link event pulse, then settle to mid-cycle for checks.
   task pulse(input logic [3:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 4'h0;
      @(negedge clk);
   endtask
   // Watchdog sized well beyond the fewer than a hundred cycles of the sequence.
   initial
   begin
      #50000;
      mismatches++;
      final_report;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h70, 32'h2);
      wb(1'b1, 8'h6C, 32'hFFFF_FFFF, 4'hF);
      rd(8'h6C, 32'h0);
      rd(8'h40, 32'h0);
      wb(1'b1, 8'h70, 32'h1F1, 4'hF);
      rd(8'h70, 32'h1D1);
      @(negedge clk);
      chk(adv, 4'h1);
      chk(cspd, 4'h1);
      chk({mar, dtx, adv_p}, 5'h1);
      chk({app, auton}, 2'h2);
      @(posedge clk) ds <= 1'b0;
      @(negedge clk) chk(adv, 4'h2);
      @(posedge clk) ds <= 1'b1;
      pulse(4'h8);
      chk(mar, 3'h3);
      pulse(4'h4);
      chk(dtx, 1'b1);
      @(posedge clk) g2 <= 1'b0;
      @(negedge clk) chk({app, dtx}, 2'h0);
      @(posedge clk) {g2, ls} <= 2'h3;
      @(negedge clk) chk({app, dtx}, 2'h0);
      pulse(4'h1);
      chk(frc, 1'b1);
      rd(8'h80, 32'h63);
      rd(8'h70, 32'h191);
      pulse(4'h2);
      rd(8'h70, 32'h011);
      wb(1'b1, 8'h70, 32'h30F, 4'h2);
      rd(8'h70, 32'h311);
      pulse(4'h8);
      chk({mar, drv}, 6'h05);
      @(posedge clk) lane <= 3'h2;
      @(negedge clk) chk(drv, 3'h2);
      wb(1'b1, 8'h70, 32'h381, 4'hF);
      pulse(4'h9);
      chk({mar, frc}, 4'h0);
      wb(1'b1, 8'h70, 32'h001, 4'hF);
      rd(8'h70, 32'h001);
      final_report;
   end
endmodule
